/* logic/cca_defines.svh */
// Register offsets, field positions, reset values and timing constants.
`ifndef CCA_DEFINES_SVH
`define CCA_DEFINES_SVH
// ****************************************************************
// Register offsets (byte addresses on the plain register port)
// ****************************************************************
`define CCA_OFS_TMR0 8'h00
`define CCA_OFS_RLD0 8'h04
`define CCA_OFS_TMR1 8'h08
`define CCA_OFS_RLD1 8'h0C
`define CCA_OFS_TCTL 8'h10
`define CCA_OFS_STAT 8'h14
`define CCA_OFS_MASK 8'h18
`define CCA_OFS_CFG_BASE 2'h1
`define CCA_OFS_VAL_BASE 2'h2
// ****************************************************************
// Field positions of the timer control register
// ****************************************************************
`define CCA_TCTL_T1_LSB 4
`define CCA_TCTL_STAGGER 8
`define CCA_TCTL_WIDTH 9
// ****************************************************************
// Reset values and timing constants
// ****************************************************************
`define CCA_RST_TMR 16'h0000
`define CCA_RST_RLD 16'h0000
`define CCA_RST_TCTL 9'h000
`define CCA_TMR_MAX 16'hFFFF
`define CCA_STAGGER_SHIFT 4'h3
`define CCA_SEL_COMPANION 3'h6
`define CCA_SEL_EXTERNAL 3'h7
`endif

/* logic/cca_pkg.sv */
// Types shared by the capture/compare array.
`default_nettype none
package cca_pkg;
   // Channel operating modes; bit 2 marks compare, bit 1 once-per-period in compare modes.
   typedef enum logic [2:0] {
      CCA_OFF     = 3'b000,
      CCA_CAP_R   = 3'b001,
      CCA_CAP_F   = 3'b010,
      CCA_CAP_RF  = 3'b011,
      CCA_CMP0    = 3'b100,
      CCA_CMP1    = 3'b101,
      CCA_CMP2    = 3'b110,
      CCA_CMP3    = 3'b111
   } cca_mode_t;

   typedef struct packed {
      logic single;
      logic dbl;
      logic tsel;
      cca_mode_t mode;
   } cca_cfg_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } cca_bus_req_t;

   typedef struct packed {
      logic [1:0][15:0] tmr;
      logic [1:0][15:0] rld;
      logic [8:0] tctl;
      logic [15:0] stat;
      logic [15:0] mask;
      logic [15:0] arm;
      logic [15:0] pin;
      logic [15:0] oe;
      logic [15:0] s1;
      logic [15:0] s2;
      logic [15:0] s3;
      logic [15:0] filt;
      logic [1:0] e1;
      logic [1:0] e2;
      logic [1:0] e3;
      logic [1:0] efilt;
      logic [1:0] adv;
      logic [7:0] psc;
      cca_cfg_t [15:0] cfg;
      logic [15:0][15:0] val;
      logic [31:0] rdata;
   } cca_state_t;
endpackage
`default_nettype wire

/* logic/cca_top.sv */
// Capture/compare array: two reloadable time bases and sixteen channels.
//
// Overview of operation
// RQ1 - Sixteen capture/compare channels, one system clock resolution.
// RQ2 - Staggered operation coarsens timer resolution to eight clocks.
// RQ3 - Two independent 16-bit timers, each with a reload register.
// RQ4 - Timer clock is a prescaled system clock or companion overflow.
// RQ5 - External count inputs can advance a timer.
// RQ6 - Each channel picks either timer and capture or compare mode.
// RQ7 - Each channel owns one pin: capture input or compare output.
// RQ8 - A capture event stores the allocated timer value.
// RQ9 - Each capture raises that channel's interrupt request.
// RQ10 - Capture edge is rising, falling or both, per channel.
// RQ11 - Compare channels match continuously against their timer.
// RQ12 - Mode 0 interrupts only, many matches per period allowed.
// RQ13 - Mode 1 toggles the pin on every match.
// RQ14 - Mode 2 interrupts only, at most once per timer period.
// RQ15 - Mode 3 sets pin on match, clears it on timer overflow.
// RQ16 - Double-register: two channels toggle one shared pin.
// RQ17 - Single-event option disables the channel after one event; here only a compare match does, captures leave it active.
// RQ18 - On overflow a timer reloads from its reload register.
// RQ19 - Compare interrupts use the channel's capture request bit.
`default_nettype none
`include "cca_defines.svh"
module cca_top import cca_pkg::*; (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire cca_bus_req_t i_bus,
   output logic [31:0] o_rd_data,
   input wire logic [15:0] i_cc_pin,
   output logic [15:0] o_cc_pin,
   output logic [15:0] o_cc_oe,
   input wire logic [1:0] i_ext_count,
   input wire logic i_companion_timer_overflow,
   output logic o_irq
);
   // ****************************************************************
   // State and per-channel decode
   // ****************************************************************
   cca_state_t s_q;
   cca_state_t s_d;
   logic [15:0] filt_nx;
   logic [15:0] cap_evt;
   logic [15:0] hit;
   logic [1:0] efilt_nx;
   logic [1:0] tick;
   logic [1:0] ovf;

   // Prescaler tap: true when the low k bits of the divider are all one.
   function automatic logic psc_hit(input logic [7:0] p,
                                    input logic [3:0] k);
      logic [8:0] m;
      m = (9'h001 << k) - 9'h001;
      return (p | ~m[7:0]) == 8'hFF;
   endfunction

   // A pin change only counts once the second and third stages agree.
   assign filt_nx = (~(s_q.s2 ^ s_q.s3) & s_q.s3)
                  | ((s_q.s2 ^ s_q.s3) & s_q.filt);
   assign efilt_nx = (~(s_q.e2 ^ s_q.e3) & s_q.e3)
                   | ((s_q.e2 ^ s_q.e3) & s_q.efilt);

   // Timer clock selection per time base.
   genvar t;
   generate
      for (t = 0; t < 2; t++) begin : g_tmr
         logic run;
         logic [2:0] sel;
         logic [3:0] k;
         assign run = s_q.tctl[t*`CCA_TCTL_T1_LSB];
         assign sel = s_q.tctl[t*`CCA_TCTL_T1_LSB+1 +: 3];
         // Staggered mode adds a divide by eight to the prescaled clock.
         assign k = {1'b0, sel}
                  + (s_q.tctl[`CCA_TCTL_STAGGER] ? `CCA_STAGGER_SHIFT
                                                  : 4'h0); // see RQ2
         // Companion overflow and external edges bypass the prescaler.
         assign tick[t] = run & ((sel == `CCA_SEL_COMPANION)
                          ? i_companion_timer_overflow // see RQ4
                          : (sel == `CCA_SEL_EXTERNAL)
                          ? (efilt_nx[t] & ~s_q.efilt[t]) // see RQ5
                          : psc_hit(s_q.psc, k)); // see RQ4
         assign ovf[t] = tick[t] & (s_q.tmr[t] == `CCA_TMR_MAX);
      end
   endgenerate

   // Per-channel capture edges and compare matches.
   genvar c;
   generate
      for (c = 0; c < 16; c++) begin : g_ch // see RQ1
         cca_cfg_t cf;
         logic rise;
         logic fall;
         assign cf = s_q.cfg[c];
         assign rise = filt_nx[c] & ~s_q.filt[c];
         assign fall = ~filt_nx[c] & s_q.filt[c];
         assign cap_evt[c] = ((cf.mode == CCA_CAP_R) & rise)
                           | ((cf.mode == CCA_CAP_F) & fall)
                           | ((cf.mode == CCA_CAP_RF)
                              & (rise | fall)); // see RQ10
         // A match counts only in the cycle after the timer moved, so
         // a timer parked on the value does not repeat the event.
         assign hit[c] = cf.mode[2] & s_q.adv[cf.tsel]
                       & (s_q.tmr[cf.tsel] == s_q.val[c])
                       & (~cf.mode[1] | s_q.arm[c]); // see RQ11
      end
   endgenerate

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   // Hardware events are applied after bus writes where they must win.
   always_comb begin
      logic [3:0] ix;
      logic [15:0] w1c;
      ix = i_bus.addr[5:2];
      w1c = 16'h0000;
      s_d = s_q;
      s_d.s1 = i_cc_pin;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      s_d.filt = filt_nx;
      s_d.e1 = i_ext_count;
      s_d.e2 = s_q.e1;
      s_d.e3 = s_q.e2;
      s_d.efilt = efilt_nx;
      s_d.psc = s_q.psc + 8'h01;
      s_d.adv = tick;
      s_d.rdata = 32'h0000_0000;
      // Bus writes.
      if (i_bus.wr) begin
         case (i_bus.addr)
            `CCA_OFS_RLD0: s_d.rld[0] = i_bus.wdata[15:0];
            `CCA_OFS_RLD1: s_d.rld[1] = i_bus.wdata[15:0];
            `CCA_OFS_TCTL: s_d.tctl = i_bus.wdata[`CCA_TCTL_WIDTH-1:0];
            `CCA_OFS_STAT: w1c = i_bus.wdata[15:0];
            `CCA_OFS_MASK: s_d.mask = i_bus.wdata[15:0];
            default: begin
               if (i_bus.addr[7:6] == `CCA_OFS_CFG_BASE) begin
                  s_d.cfg[ix] = cca_cfg_t'(i_bus.wdata[5:0]); // see RQ6
                  s_d.arm[ix] = 1'b1;
               end else if (i_bus.addr[7:6] == `CCA_OFS_VAL_BASE) begin
                  s_d.val[ix] = i_bus.wdata[15:0];
               end
            end
         endcase
      end
      // Timers count and reload; a software write to a timer wins.
      for (int i = 0; i < 2; i++) begin
         if (ovf[i]) begin
            s_d.tmr[i] = s_q.rld[i]; // see RQ18
         end else if (tick[i]) begin
            s_d.tmr[i] = s_q.tmr[i] + 16'h0001; // see RQ3
         end
      end
      if (i_bus.wr && i_bus.addr == `CCA_OFS_TMR0) begin
         s_d.tmr[0] = i_bus.wdata[15:0];
      end
      if (i_bus.wr && i_bus.addr == `CCA_OFS_TMR1) begin
         s_d.tmr[1] = i_bus.wdata[15:0];
      end
      // Channel actions.
      for (int i = 0; i < 16; i++) begin
         if (cap_evt[i]) begin
            s_d.val[i] = s_q.tmr[s_q.cfg[i].tsel]; // see RQ8
         end
         if (s_q.cfg[i].mode == CCA_CMP3 && ovf[s_q.cfg[i].tsel]) begin
            s_d.pin[i] = 1'b0; // see RQ15
         end
         if (hit[i]) begin // see RQ12
            s_d.arm[i] = 1'b0; // see RQ14
            if (s_q.cfg[i].mode == CCA_CMP1) begin
               s_d.pin[i] = ~s_d.pin[i]; // see RQ13
            end
            if (s_q.cfg[i].mode == CCA_CMP3) begin
               s_d.pin[i] = 1'b1; // see RQ15
            end
            if (s_q.cfg[i].single) begin
               s_d.cfg[i].mode = CCA_OFF; // see RQ17
            end
         end
         // A hit on the partner channel also toggles the shared pin.
         if (i < 8 && s_q.cfg[i].dbl && hit[(i+8)%16]) begin
            s_d.pin[i] = ~s_d.pin[i]; // see RQ16
         end
         // Re-arm for the next period; overflow comes after the hit.
         if (ovf[s_q.cfg[i].tsel]) begin
            s_d.arm[i] = 1'b1;
         end
         s_d.oe[i] = (s_d.cfg[i].mode == CCA_CMP1)
                   | (s_d.cfg[i].mode == CCA_CMP3)
                   | ((i < 8) & s_d.cfg[i].dbl); // see RQ7
      end
      // Set wins over write-one-to-clear.
      s_d.stat = (s_q.stat & ~w1c) | cap_evt | hit; // see RQ9 see RQ19
      // Read data stands for exactly the cycle after the strobe.
      if (i_bus.rd) begin
         case (i_bus.addr)
            `CCA_OFS_TMR0: s_d.rdata = {16'h0000, s_q.tmr[0]};
            `CCA_OFS_RLD0: s_d.rdata = {16'h0000, s_q.rld[0]};
            `CCA_OFS_TMR1: s_d.rdata = {16'h0000, s_q.tmr[1]};
            `CCA_OFS_RLD1: s_d.rdata = {16'h0000, s_q.rld[1]};
            `CCA_OFS_TCTL: s_d.rdata = {23'h000000, s_q.tctl};
            `CCA_OFS_STAT: s_d.rdata = {16'h0000, s_q.stat};
            `CCA_OFS_MASK: s_d.rdata = {16'h0000, s_q.mask};
            default: begin
               if (i_bus.addr[7:6] == `CCA_OFS_CFG_BASE) begin
                  s_d.rdata = {26'h0000000, s_q.cfg[ix]};
               end else if (i_bus.addr[7:6] == `CCA_OFS_VAL_BASE) begin
                  s_d.rdata = {16'h0000, s_q.val[ix]};
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // Synchronous reset returns every field to a constant.
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         s_q <= '0;
         s_q.tmr <= {`CCA_RST_TMR, `CCA_RST_TMR};
         s_q.rld <= {`CCA_RST_RLD, `CCA_RST_RLD};
         s_q.tctl <= `CCA_RST_TCTL;
         s_q.arm <= 16'hFFFF;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rd_data = s_q.rdata;
   assign o_cc_pin = s_q.pin;
   assign o_cc_oe = s_q.oe;
   assign o_irq = |(s_q.stat & s_q.mask);

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   sequence s_cmp3_match;
      hit[3] && s_q.cfg[3].mode == CCA_CMP3 && !s_q.cfg[3].dbl;
   endsequence
   sequence s_pin3_high;
      o_cc_pin[3] [*1];
   endsequence

   a_capture_store: assert property ( // see RQ8
      cap_evt[6] |=> s_q.val[6] == $past(s_q.tmr[s_q.cfg[6].tsel]))
      else $error("capture did not store the timer value");
   a_capture_irq: assert property ( // see RQ9
      cap_evt[4] |=> s_q.stat[4] && (o_irq || !s_q.mask[4]))
      else $error("capture did not raise its request");
   a_edge_rise: assert property ( // see RQ10
      cap_evt[4] && s_q.cfg[4].mode == CCA_CAP_R
      |-> filt_nx[4] && !s_q.filt[4])
      else $error("rising capture without a rising edge");
   a_timer_reload: assert property ( // see RQ18
      ovf[0] && !(i_bus.wr && i_bus.addr == `CCA_OFS_TMR0)
      |=> s_q.tmr[0] == $past(s_q.rld[0]))
      else $error("timer did not reload on overflow");
   a_mode1_toggle: assert property ( // see RQ13
      hit[1] && s_q.cfg[1].mode == CCA_CMP1
      |=> o_cc_pin[1] != $past(o_cc_pin[1]))
      else $error("mode 1 match did not toggle the pin");
   a_mode3_set: assert property ( // see RQ15
      s_cmp3_match |=> s_pin3_high)
      else $error("mode 3 match did not set the pin");
   a_mode2_once: assert property ( // see RQ14
      hit[2] && s_q.cfg[2].mode == CCA_CMP2 && !ovf[s_q.cfg[2].tsel]
      |=> !s_q.arm[2] ##1 !hit[2])
      else $error("mode 2 matched twice in one period");
   a_single_off: assert property ( // see RQ17
      hit[9] && s_q.cfg[9].single |=> s_q.cfg[9].mode == CCA_OFF
      ##1 !hit[9])
      else $error("single event channel stayed active");
   a_stagger_tick: assert property ( // see RQ2
      s_q.tctl[`CCA_TCTL_STAGGER] && tick[0]
      && s_q.tctl[3:1] < `CCA_SEL_COMPANION
      |-> s_q.psc[2:0] == 3'h7 ##1 !tick[0] [*7])
      else $error("staggered timer ticked faster than eight clocks");
   a_irq_level: assert property ( // see RQ19
      hit[0] && s_q.mask[0] && !(i_bus.wr && i_bus.addr == `CCA_OFS_MASK)
      |=> o_irq)
      else $error("compare match did not assert the interrupt");
   // Mode 0 raises only its request; the pin keeps its level.
   a_mode0_pin: assert property ( // see RQ12
      hit[0] && s_q.cfg[0].mode == CCA_CMP0 && !s_q.cfg[0].dbl
      |=> o_cc_pin[0] == $past(o_cc_pin[0]) && s_q.stat[0])
      else $error("mode 0 match touched the pin or lost its request");
   // Overflow of the allocated timer pulls a mode 3 pin low again.
   sequence s_cmp3_ovf;
      s_q.cfg[3].mode == CCA_CMP3 && ovf[s_q.cfg[3].tsel]
      && !hit[3] && !s_q.cfg[3].dbl;
   endsequence
   sequence s_pin3_low;
      !o_cc_pin[3] [*1];
   endsequence
   a_mode3_clear: assert property ( // see RQ15
      s_cmp3_ovf |=> s_pin3_low)
      else $error("mode 3 pin stayed high after overflow");
   // A partner match flips the shared pin of an otherwise idle channel.
   a_double_flip: assert property ( // see RQ16
      hit[15] && s_q.cfg[7].dbl && s_q.cfg[7].mode == CCA_OFF
      |=> o_cc_pin[7] != $past(o_cc_pin[7]))
      else $error("partner match did not flip the shared pin");
   // Compare outputs drive their pad and capture inputs without the double-register bit leave it free.
   a_oe_compare: assert property ( // see RQ7
      s_q.cfg[1].mode == CCA_CMP1 |-> o_cc_oe[1])
      else $error("toggling channel does not drive its pin");
   a_oe_capture: assert property ( // see RQ7
      s_q.cfg[4].mode == CCA_CAP_R && !s_q.cfg[4].dbl |-> !o_cc_oe[4])
      else $error("capture channel drives its pin");
   // A timer step adds one unless it reloads or software writes it.
   a_timer_step: assert property ( // see RQ3
      tick[1] && !ovf[1] && !(i_bus.wr && i_bus.addr == `CCA_OFS_TMR1)
      |=> s_q.tmr[1] == $past(s_q.tmr[1]) + 16'h0001)
      else $error("timer did not advance by one");
   // An external count edge advances the timer exactly once.
   a_ext_once: assert property ( // see RQ5
      tick[1] && s_q.tctl[7:5] == `CCA_SEL_EXTERNAL && !i_bus.wr
      |=> !tick[1])
      else $error("one external edge counted twice");
   // A companion overflow pulse is one step of a timer that selects it.
   a_companion_step: assert property ( // see RQ4
      s_q.tctl[0] && s_q.tctl[3:1] == `CCA_SEL_COMPANION
      && i_companion_timer_overflow && s_q.tmr[0] != `CCA_TMR_MAX
      && !(i_bus.wr && i_bus.addr == `CCA_OFS_TMR0)
      |=> s_q.tmr[0] == $past(s_q.tmr[0]) + 16'h0001)
      else $error("companion overflow did not step the timer");
   // A request bit stays set until software writes a one to it.
   a_stat_sticky: assert property ( // see RQ9
      s_q.stat[4] && !(i_bus.wr && i_bus.addr == `CCA_OFS_STAT
      && i_bus.wdata[4]) |=> s_q.stat[4])
      else $error("request bit cleared without a write");
   // A rising-only channel ignores a falling pin.
   a_fall_ignored: assert property ( // see RQ10
      s_q.cfg[4].mode == CCA_CAP_R && !filt_nx[4] && s_q.filt[4]
      |-> !cap_evt[4])
      else $error("rising-only channel captured a falling edge");
   a_edge_fall: assert property ( // see RQ10
      cap_evt[5] && s_q.cfg[5].mode == CCA_CAP_F |=> !s_q.filt[5])
      else $error("falling capture without a falling edge");
endmodule
`default_nettype wire

/* testbench/cca_ext_model.sv */
// Model of the outside world at the channel pins and count inputs.
`default_nettype none
module cca_ext_model (
   input wire logic i_clk,
   input wire logic [15:0] i_pin_out,
   input wire logic [15:0] i_pin_oe,
   output logic [15:0] o_pin_in,
   output logic [1:0] o_ext,
   output logic o_ovf
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] drv;
   // Pad level: the design wins where it drives, the outside elsewhere.
   assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & drv);
   initial begin
      drv = '0;
      o_ext = '0;
      o_ovf = 1'b0;
   end
   // One companion overflow pulse; a long gap models a slow source.
   task automatic ovf(input int gap);
      @(posedge i_clk);
      o_ovf <= 1'b1;
      @(posedge i_clk);
      o_ovf <= 1'b0;
      repeat (gap) @(posedge i_clk);
   endtask
   // Count pulse held long enough to cross the input synchroniser.
   task automatic ext(input int t);
      @(posedge i_clk);
      o_ext[t] <= 1'b1;
      repeat (3) @(posedge i_clk);
      o_ext[t] <= 1'b0;
      repeat (4) @(posedge i_clk);
   endtask
   // Drive the pins under m to v, then hold for the sync chain.
   task automatic pin(input logic [15:0] m, input logic [15:0] v);
      @(posedge i_clk);
      drv <= (drv & ~m) | (v & m);
      repeat (8) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

/* testbench/tb_capture_compare_array.sv */
// Self-checking bench for the capture/compare array.
`default_nettype none
`include "cca_defines.svh"
module tb_capture_compare_array;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, ovf, irq;
   cca_pkg::cca_bus_req_t bus;
   logic [31:0] rdat, seed, d;
   logic [15:0] pin_in, pin_out, oe;
   logic [1:0] ext;
   int n_errors, n_checks, v, mask, m_arm, m_stat, m_pin;
   int m_tmr[2], m_rld[2], m_cfg[16], m_val[16];
   cca_top u_cca_top(.i_sys_clk(clk), .i_rst(rst), .i_bus(bus),
      .o_rd_data(rdat), .i_cc_pin(pin_in), .o_cc_pin(pin_out),
      .o_cc_oe(oe), .i_ext_count(ext),
      .i_companion_timer_overflow(ovf), .o_irq(irq));
   cca_ext_model u_ext(.i_clk(clk), .i_pin_out(pin_out), .i_pin_oe(oe),
      .o_pin_in(pin_in), .o_ext(ext), .o_ovf(ovf));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ****************************************
   // Helpers and reference model
   // ****************************************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic summarize();
      $display("Checks %0d, errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Bus cycles leave an idle cycle so no strobe is assigned twice.
   task automatic wr(input logic [7:0] a, input logic [31:0] w);
      @(posedge clk);
      bus <= {a, w, 2'b10};
      @(posedge clk);
      bus <= '0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      bus <= {a, 32'h0, 2'b01};
      @(posedge clk);
      bus <= '0;
      #1 chk(rdat, e);
   endtask
   // Timer step: reload at the top, then every compare channel allocated to that timer is tried.
   function automatic void mstep(int t);
      if (m_tmr[t] == 'hFFFF) begin
         m_tmr[t] = m_rld[t];
         for (int c = 0; c < 16; c++) if (m_cfg[c][3] == t) begin
            m_arm |= 1 << c;
            if (m_cfg[c][2:0] == 7) m_pin &= ~(1 << c);
         end
      end else m_tmr[t]++;
      for (int c = 0; c < 16; c++) if (m_cfg[c][2] && m_cfg[c][3] == t &&
            m_val[c] == m_tmr[t] && (m_cfg[c][1:0] < 2 || m_arm[c])) begin
         m_stat |= 1 << c;
         m_arm &= ~(1 << c);
         if (m_cfg[c][1:0] == 1) m_pin ^= 1 << c;
         if (m_cfg[c][1:0] == 3) m_pin |= 1 << c;
         if (c > 7 && m_cfg[c-8][4]) m_pin ^= 1 << (c - 8);
         if (m_cfg[c][5]) m_cfg[c] &= ~7;
      end
   endfunction
   task automatic tick(input int t, input int n);
      repeat (n) begin
         if (t == 0) u_ext.ovf(2 + int'(rnd() & 3));
         else u_ext.ext(1);
         mstep(t);
      end
   endtask
   task automatic wcfg(input int c, input int w);
      wr({`CCA_OFS_CFG_BASE, 4'(c), 2'b00}, w);
      m_cfg[c] = w;
      m_arm |= 1 << c;
   endtask
   task automatic wval(input int c, input int w);
      wr({`CCA_OFS_VAL_BASE, 4'(c), 2'b00}, w);
      m_val[c] = w;
   endtask
   task automatic wtmr(input int t, input int w);
      wr(t ? `CCA_OFS_TMR1 : `CCA_OFS_TMR0, w);
      m_tmr[t] = w;
   endtask
   task automatic wstat(input int w);
      wr(`CCA_OFS_STAT, w);
      m_stat &= ~w;
   endtask
   // Pins settle within a bounded wait; running out ends the run.
   task automatic pchk();
      int i;
      i = 0;
      #1;
      while (pin_out !== m_pin[15:0] && i < 12) begin
         @(posedge clk);
         #1;
         i++;
      end
      chk(32'(pin_out), 32'(m_pin[15:0]));
      if (pin_out !== m_pin[15:0]) summarize();
   endtask
   task automatic ichk();
      @(posedge clk);
      #1 chk(32'(irq), 32'(|(m_stat & mask)));
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rst = 1'b1;
      bus = '0;
      seed = 32'h1103;
      mask = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 'h1C; a += 4) rchk(8'(a), 0);
      rchk(8'hFC, 0);
      wr(`CCA_OFS_TCTL, 1);
      repeat (40) @(posedge clk);
      rd_range(40, 46);
      wr(`CCA_OFS_TCTL, 'h101);
      wtmr(0, 0);
      repeat (80) @(posedge clk);
      rd_range(9, 12);
      wr(`CCA_OFS_TCTL, 'hFD);
      rchk(`CCA_OFS_TCTL, 'hFD);
      m_rld[0] = int'(rnd() & 'hFFFF);
      wr(`CCA_OFS_RLD0, m_rld[0]);
      wtmr(0, 'hFFFE);
      tick(0, 2);
      rchk(`CCA_OFS_TMR0, m_tmr[0]);
      wtmr(1, 5);
      tick(1, 3);
      rchk(`CCA_OFS_TMR1, m_tmr[1]);
      v = int'(rnd() & 'h7FF) | 'h100;
      for (int c = 0; c < 4; c++) begin
         wcfg(c, 4 + c);
         wval(c, v);
      end
      wtmr(0, v - 1);
      tick(0, 1);
      rchk(`CCA_OFS_STAT, m_stat);
      pchk();
      chk(32'(oe), 32'h000A);
      mask = 'hF;
      wr(`CCA_OFS_MASK, mask);
      ichk();
      wstat('hF);
      ichk();
      wtmr(0, v - 1);
      tick(0, 1);
      rchk(`CCA_OFS_STAT, m_stat);
      pchk();
      wtmr(0, 'hFFFF);
      tick(0, 1);
      pchk();
      wcfg(7, 'h10);
      wcfg(9, 'h25);
      wval(9, v + 2);
      wcfg(15, 5);
      wval(15, v + 3);
      wstat('hFFFF);
      wtmr(0, v + 1);
      for (int k = 0; k < 2; k++) begin
         tick(0, 1);
         pchk();
      end
      rchk({`CCA_OFS_CFG_BASE, 4'd9, 2'b00}, m_cfg[9]);
      wtmr(0, v + 1);
      tick(0, 2);
      pchk();
      rchk(`CCA_OFS_STAT, m_stat);
      wcfg(4, 1);
      wcfg(5, 2);
      wcfg(6, 'hB);
      wstat('hFFFF);
      wtmr(0, int'(rnd() & 'hFFFF));
      mask = int'(rnd() & 'hFFFF);
      wr(`CCA_OFS_MASK, mask);
      for (int e = 1; e >= 0; e--) begin
         u_ext.pin('h70, e ? 'h70 : 0);
         for (int c = 4; c < 7; c++) if (m_cfg[c][e ? 0 : 1]) begin
            m_stat |= 1 << c;
            m_val[c] = m_tmr[m_cfg[c][3]];
         end
         rchk(`CCA_OFS_STAT, m_stat);
         ichk();
         for (int c = 4; c < 7; c++)
            rchk({`CCA_OFS_VAL_BASE, 4'(c), 2'b00}, m_val[c]);
         wstat('h70);
      end
      summarize();
   end
   // Free-running count read back against a window for prescaler phase.
   task automatic rd_range(input int lo, input int hi);
      @(posedge clk);
      bus <= {`CCA_OFS_TMR0, 32'h0, 2'b01};
      @(posedge clk);
      bus <= '0;
      #1 d = rdat;
      chk(32'(d >= lo && d <= hi), 1);
   endtask
endmodule
`default_nettype wire
